// *** hdl/fps_flash_seq.sv ***
// flash program and verify sequencer with axi4-lite control registers
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module fps_flash_seq
  import fps_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // external write-enable pin
  input wire logic flash_write_enable_pin,
  // cpu access to the flash address space
  input wire fps_freq_type fl_req,
  output logic fl_rvalid,
  output logic [15:0] fl_rdata,
  output logic fl_rd_busy,
  // array side
  output logic [FL_AW-1:0] arr_addr,
  input wire logic [15:0] arr_rdata,
  output logic arr_prog,
  output logic [PAGE_IW-1:0] arr_prog_idx,
  output logic [7:0] arr_prog_data,
  output logic [1:0] arr_erase
);

  // ----------------------------------------------------------------
  // control registers and derived modes
  // ----------------------------------------------------------------
  fps_ctrl_type lower_half_flash_control_ff, nxt_lower_ctrl;
  fps_ctrl_type upper_half_flash_control_ff, nxt_upper_ctrl;
  logic [1:0] prog_act, erase_act, swe_on, verify_on;

  // program and erase only take effect with the pin high and the half enabled
  always_comb
  begin
    prog_act[0] = flash_write_enable_pin & lower_half_flash_control_ff.swe
      & lower_half_flash_control_ff.setup
      & lower_half_flash_control_ff.pulse;
    prog_act[1] = flash_write_enable_pin & upper_half_flash_control_ff.swe
      & upper_half_flash_control_ff.setup
      & upper_half_flash_control_ff.pulse;
    erase_act[0] = flash_write_enable_pin & lower_half_flash_control_ff.swe
      & lower_half_flash_control_ff.erase_setup
      & lower_half_flash_control_ff.erase_pulse;
    erase_act[1] = flash_write_enable_pin & upper_half_flash_control_ff.swe
      & upper_half_flash_control_ff.erase_setup
      & upper_half_flash_control_ff.erase_pulse;
    swe_on = {upper_half_flash_control_ff.swe,
      lower_half_flash_control_ff.swe};
    verify_on[0] = lower_half_flash_control_ff.verify
      | lower_half_flash_control_ff.erase_verify;
    verify_on[1] = upper_half_flash_control_ff.verify
      | upper_half_flash_control_ff.erase_verify;
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic aw_have_ff, nxt_aw_have;
  logic w_have_ff, nxt_w_have;
  logic [AXI_AW-1:0] waddr_ff, nxt_waddr;
  logic [31:0] wdat_ff, nxt_wdat;
  logic wlane_ff, nxt_wlane;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic do_write;

  // address and data may arrive in either order; one write in flight
  always_comb
  begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_waddr = waddr_ff;
    nxt_wdat = wdat_ff;
    nxt_wlane = wlane_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    do_write = 1'b0;
    if (awvalid && awready_ff)
    begin
      nxt_aw_have = 1'b1;
      nxt_waddr = awaddr;
    end
    if (wvalid && wready_ff)
    begin
      nxt_w_have = 1'b1;
      nxt_wdat = wdata;
      nxt_wlane = wstrb[0];
    end
    if (aw_have_ff && w_have_ff && !bvalid_ff)
    begin
      do_write = 1'b1;
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (waddr_ff == LOWER_CTRL_OFS || waddr_ff == UPPER_CTRL_OFS
        || waddr_ff == STATUS_OFS) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_ff && bready)
      nxt_bvalid = 1'b0;
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready = !nxt_w_have && !nxt_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      waddr_ff <= '0;
      wdat_ff <= '0;
      wlane_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else
    begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      waddr_ff <= nxt_waddr;
      wdat_ff <= nxt_wdat;
      wlane_ff <= nxt_wlane;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // control writes; a low pin wipes both registers and blocks writes
  always_comb
  begin
    nxt_lower_ctrl = lower_half_flash_control_ff;
    nxt_upper_ctrl = upper_half_flash_control_ff;
    if (do_write && wlane_ff && waddr_ff == LOWER_CTRL_OFS)
      nxt_lower_ctrl = fps_ctrl_type'(wdat_ff[CTRL_W-1:0]);
    if (do_write && wlane_ff && waddr_ff == UPPER_CTRL_OFS)
      nxt_upper_ctrl = fps_ctrl_type'(wdat_ff[CTRL_W-1:0]);
    if (!flash_write_enable_pin)
    begin
      nxt_lower_ctrl = CTRL_RST;
      nxt_upper_ctrl = CTRL_RST;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lower_half_flash_control_ff <= CTRL_RST;
      upper_half_flash_control_ff <= CTRL_RST;
    end
    else
    begin
      lower_half_flash_control_ff <= nxt_lower_ctrl;
      upper_half_flash_control_ff <= nxt_upper_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // page latch and flash-space accesses
  // ----------------------------------------------------------------
  logic [7:0] page_mem [0:PAGE_BYTES-1];
  logic [FL_AW-1:0] lat_addr_ff, nxt_lat_addr;
  logic [7:0] byte_cnt_ff, nxt_byte_cnt;
  logic [PAGE_IW-1:0] prog_idx_ff, nxt_prog_idx;
  logic [FL_AW-1:0] arr_addr_ff, nxt_arr_addr;
  logic rd_pend_ff, nxt_rd_pend;
  logic rd_bad_ff, nxt_rd_bad;
  logic fl_rvalid_ff, nxt_fl_rvalid;
  logic [15:0] fl_rdata_ff, nxt_fl_rdata;
  logic fl_rd_busy_ff, nxt_fl_rd_busy;
  logic arr_prog_ff, nxt_arr_prog;
  logic [7:0] arr_data_ff, nxt_arr_data;
  logic [1:0] arr_erase_ff;
  logic page_we;
  logic req_half, lat_half, busy, pulse_now;

  // pulse belongs to the half holding the latched page
  always_comb
  begin
    req_half = fl_req.addr[HALF_BIT];
    lat_half = lat_addr_ff[HALF_BIT];
    busy = |prog_act | |erase_act;
    pulse_now = prog_act[lat_half];
    nxt_lat_addr = lat_addr_ff;
    nxt_byte_cnt = byte_cnt_ff;
    page_we = 1'b0;
    nxt_rd_pend = 1'b0;
    nxt_rd_bad = 1'b0;
    nxt_arr_addr = arr_addr_ff;
    if (fl_req.req && fl_req.we && !busy)
    begin
      if (verify_on[req_half])
        nxt_lat_addr = fl_req.addr;
      else if (swe_on[req_half])
      begin
        page_we = 1'b1;
        nxt_lat_addr = fl_req.addr;
        // a byte into another page starts a fresh count
        if (fl_req.addr[FL_AW-1:PAGE_IW] != lat_addr_ff[FL_AW-1:PAGE_IW]
          || byte_cnt_ff == CNT_FULL)
          nxt_byte_cnt = 8'h01;
        else
          nxt_byte_cnt = byte_cnt_ff + 8'h01;
      end
    end
    if (fl_req.req && !fl_req.we)
    begin
      nxt_rd_pend = 1'b1;
      nxt_rd_bad = busy;
      // verify reads come from the latched word, not the bus address
      nxt_arr_addr = verify_on[req_half] ? lat_addr_ff : fl_req.addr;
      nxt_arr_addr[0] = 1'b0;
    end
    // while pulsing, walk the page bytes into the array
    nxt_arr_prog = pulse_now;
    nxt_prog_idx = pulse_now ? prog_idx_ff + 7'h01 : '0;
    nxt_arr_data = page_mem[prog_idx_ff];
    if (pulse_now)
      nxt_arr_addr = {lat_addr_ff[FL_AW-1:PAGE_IW], prog_idx_ff};
    nxt_fl_rvalid = rd_pend_ff;
    nxt_fl_rd_busy = rd_pend_ff && rd_bad_ff;
    nxt_fl_rdata = fl_rdata_ff;
    if (rd_pend_ff)
      nxt_fl_rdata = rd_bad_ff ? READ_INVALID : arr_rdata;
  end

  // the page latch has no reset; software refills all bytes per page
  always_ff @(posedge aclk)
  begin
    if (page_we)
      page_mem[fl_req.addr[PAGE_IW-1:0]] <= fl_req.wdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lat_addr_ff <= '0;
      byte_cnt_ff <= '0;
      prog_idx_ff <= '0;
      arr_addr_ff <= '0;
      rd_pend_ff <= 1'b0;
      rd_bad_ff <= 1'b0;
      fl_rvalid_ff <= 1'b0;
      fl_rdata_ff <= '0;
      fl_rd_busy_ff <= 1'b0;
      arr_prog_ff <= 1'b0;
      arr_data_ff <= '0;
      arr_erase_ff <= '0;
    end
    else
    begin
      lat_addr_ff <= nxt_lat_addr;
      byte_cnt_ff <= nxt_byte_cnt;
      prog_idx_ff <= nxt_prog_idx;
      arr_addr_ff <= nxt_arr_addr;
      rd_pend_ff <= nxt_rd_pend;
      rd_bad_ff <= nxt_rd_bad;
      fl_rvalid_ff <= nxt_fl_rvalid;
      fl_rdata_ff <= nxt_fl_rdata;
      fl_rd_busy_ff <= nxt_fl_rd_busy;
      arr_prog_ff <= nxt_arr_prog;
      arr_data_ff <= nxt_arr_data;
      arr_erase_ff <= erase_act;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  // status shows live program and erase modes, the pin and the bytes latched so far
  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && rready)
      nxt_rvalid = 1'b0;
    if (arvalid && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = '0;
      unique case (araddr)
        LOWER_CTRL_OFS: nxt_rdata[CTRL_W-1:0] = lower_half_flash_control_ff;
        UPPER_CTRL_OFS: nxt_rdata[CTRL_W-1:0] = upper_half_flash_control_ff;
        STATUS_OFS:
        begin
          nxt_rdata[ST_LOWER_PROG] = prog_act[0];
          nxt_rdata[ST_UPPER_PROG] = prog_act[1];
          nxt_rdata[ST_LOWER_ERASE] = erase_act[0];
          nxt_rdata[ST_UPPER_ERASE] = erase_act[1];
          nxt_rdata[ST_PIN] = flash_write_enable_pin;
          nxt_rdata[ST_CNT_LSB+7:ST_CNT_LSB] = byte_cnt_ff;
        end
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else
    begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign fl_rvalid = fl_rvalid_ff;
  assign fl_rdata = fl_rdata_ff;
  assign fl_rd_busy = fl_rd_busy_ff;
  assign arr_addr = arr_addr_ff;
  assign arr_prog = arr_prog_ff;
  assign arr_prog_idx = prog_idx_ff;
  assign arr_prog_data = arr_data_ff;
  assign arr_erase = arr_erase_ff;

endmodule : fps_flash_seq

// *** hdl/fps_pkg.sv ***
// constants, field layouts and carrier types of the flash program sequencer
// What this block does
// - two control registers select modes per half
// - reads during program or erase return invalid
// - write-enable pin low blocks program and erase
// - 128 byte writes latched as address and data
// - setup then pulse; programming lasts while pulse set
// - verify: dummy write, wait, read latched word
// - write pulse applied only while pulse bit set
package fps_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int AXI_AW = 12;
  localparam logic [AXI_AW-1:0] LOWER_CTRL_OFS = 12'h000;
  localparam logic [AXI_AW-1:0] UPPER_CTRL_OFS = 12'h004;
  localparam logic [AXI_AW-1:0] STATUS_OFS = 12'h008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control field positions, low seven bits of each control register
  localparam int CTRL_W = 7;
  localparam int PULSE_BIT = 0;
  localparam int ERASE_PULSE_BIT = 1;
  localparam int VERIFY_BIT = 2;
  localparam int ERASE_VERIFY_BIT = 3;
  localparam int SETUP_BIT = 4;
  localparam int ERASE_SETUP_BIT = 5;
  localparam int SWE_BIT = 6;

  // status field positions
  localparam int ST_LOWER_PROG = 0;
  localparam int ST_UPPER_PROG = 1;
  localparam int ST_LOWER_ERASE = 2;
  localparam int ST_UPPER_ERASE = 3;
  localparam int ST_PIN = 4;
  localparam int ST_CNT_LSB = 8;

  // ----------------------------------------------------------------
  // flash space
  // ----------------------------------------------------------------
  localparam int FL_AW = 19;
  localparam int HALF_BIT = 18;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_IW = 7;
  localparam logic [15:0] READ_INVALID = 16'hffff;
  localparam logic [7:0] CNT_FULL = 8'h80;

  typedef struct packed {
    logic swe;
    logic erase_setup;
    logic setup;
    logic erase_verify;
    logic verify;
    logic erase_pulse;
    logic pulse;
  } fps_ctrl_type;

  localparam fps_ctrl_type CTRL_RST = 7'h00;

  // one access from the cpu into the flash address space
  typedef struct packed {
    logic req;
    logic we;
    logic [FL_AW-1:0] addr;
    logic [7:0] wdata;
  } fps_freq_type;

endpackage : fps_pkg

// *** sim/fps_flash_seq_sva.sv ***
// port-level assertion checker for the flash program sequencer
`timescale 1ns/1ps
module fps_flash_seq_sva
  import fps_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // flash space and array side
  input wire logic flash_write_enable_pin,
  input wire fps_freq_type fl_req,
  input wire logic fl_rvalid,
  input wire logic [15:0] fl_rdata,
  input wire logic fl_rd_busy,
  input wire logic arr_prog,
  input wire logic [PAGE_IW-1:0] arr_prog_idx,
  input wire logic [1:0] arr_erase
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------
  // pin gating and write pulse
  // ------------------------------
  // two low edges give a registered clear time to land
  a_pin_low_stops: assert property (
    !flash_write_enable_pin [*2] |=> !arr_prog && arr_erase == 2'h0)
    else $error("array pulse with pin low");
  a_pulse_needs_pin: assert property (
    arr_prog |-> $past(flash_write_enable_pin))
    else $error("write pulse without pin");
  a_idx_walk: assert property (
    arr_prog && $past(arr_prog) |->
      arr_prog_idx == $past(arr_prog_idx) + 7'h01)
    else $error("page index did not step");

  // ------------------------------
  // flash space reads
  // ------------------------------
  a_read_lat: assert property (
    fl_req.req && !fl_req.we |-> ##2 fl_rvalid)
    else $error("flash read answer late");
  a_read_busy: assert property (
    arr_prog && fl_req.req && !fl_req.we ##1 arr_prog |->
      ##1 fl_rd_busy && fl_rdata == READ_INVALID)
    else $error("read during pulse not refused");
  a_busy_valid: assert property (
    fl_rd_busy |-> fl_rvalid)
    else $error("busy flag without answer");

  // ------------------------------
  // control register access
  // ------------------------------
  a_b_answer: assert property (
    bvalid && bready |=> !bvalid)
    else $error("write response not released");
  a_r_answer: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
endmodule : fps_flash_seq_sva

bind fps_flash_seq fps_flash_seq_sva u_sva (
  .aclk, .aresetn, .bvalid, .bready, .arvalid, .arready, .rvalid,
  .flash_write_enable_pin, .fl_req, .fl_rvalid, .fl_rdata, .fl_rd_busy,
  .arr_prog, .arr_prog_idx, .arr_erase
);

// *** sim/fps_flash_seq_tb_top.sv ***
// self-checking bench for the flash program sequencer
`timescale 1ns/1ps
module fps_flash_seq_tb_top
  import fps_pkg::*;
;
  typedef struct packed {
    logic [AXI_AW-1:0] a;
    logic [31:0] d;
    logic [1:0] wr;
    logic [31:0] rd;
    logic [1:0] rr;
  } fps_row_type;

  // register write, its response, then the read-back expected
  localparam fps_row_type ROWS [4] = '{
    '{LOWER_CTRL_OFS, 32'h40, RESP_OKAY, 32'h40, RESP_OKAY},
    '{UPPER_CTRL_OFS, 32'h44, RESP_OKAY, 32'h44, RESP_OKAY},
    '{UPPER_CTRL_OFS, 32'h00, RESP_OKAY, 32'h00, RESP_OKAY},
    '{12'h00c, 32'h7f, RESP_SLVERR, 32'h00, RESP_SLVERR}
  };

  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, fl_rvalid;
  logic fl_rd_busy, arr_prog, flash_write_enable_pin, pp;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r, arr_erase;
  logic [15:0] fl_rdata, arr_rdata;
  logic [FL_AW-1:0] arr_addr;
  logic [PAGE_IW-1:0] arr_prog_idx, pi;
  logic [7:0] arr_prog_data, rpg;
  fps_freq_type fl_req;
  int n_errors = 0;
  int tests_run = 0;

  always #2 aclk = ~aclk;
  // array word follows its address, so a wrong address shows
  assign arr_rdata = arr_addr[15:0] ^ 16'hc3a5;

  fps_flash_seq dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .flash_write_enable_pin, .fl_req, .fl_rvalid,
    .fl_rdata, .fl_rd_busy, .arr_addr, .arr_rdata, .arr_prog,
    .arr_prog_idx, .arr_prog_data, .arr_erase
  );

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk

  // reprogram byte: zero only where source is 0 and verify read 1
  function automatic logic [7:0] reprog(input logic [7:0] s,
                                        input logic [7:0] v);
    return s | ~v;
  endfunction : reprog

  // extra byte: zero only where reprogram is 0 and verify read 0
  function automatic logic [7:0] addprog(input logic [7:0] x,
                                         input logic [7:0] v);
    return x | v;
  endfunction : addprog

  // address and data released each at its own take
  task automatic axw(input logic [AXI_AW-1:0] a, input logic [31:0] v);
    logic ad = 1'b0;
    logic dd = 1'b0;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= v;
    bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      ad = ad || awready;
      dd = dd || wready;
      awvalid <= !ad;
      wvalid <= !dd;
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask : axw

  task automatic axr(input logic [AXI_AW-1:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      arvalid <= arvalid && !arready;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : axr

  task automatic fl_acc(input logic we, input logic [FL_AW-1:0] a,
                        input logic [7:0] v);
    @(posedge aclk);
    fl_req <= '{1'b1, we, a, v};
    @(posedge aclk);
    fl_req.req <= 1'b0;
  endtask : fl_acc

  task automatic fl_rd(input logic [FL_AW-1:0] a, input logic bz,
                       input logic [15:0] e);
    fl_acc(1'b0, a, 8'h00);
    repeat (2) @(posedge aclk);
    chk("fl_rvalid", 32'h1, fl_rvalid);
    chk("fl_rd_busy", bz, fl_rd_busy);
    chk("fl_rdata", e, fl_rdata);
  endtask : fl_rd

  task end_sim;
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_sim;
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, araddr, wdata} <= '0;
    fl_req <= '0;
    flash_write_enable_pin <= 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // ready still shows its reset level at the first edge after release
    @(posedge aclk);
    chk("awready reset", 32'h0, awready);
    @(posedge aclk);
    chk("awready", 32'h1, awready);
    axr(LOWER_CTRL_OFS);
    chk("ctrl reset", 32'h0, d);
    foreach (ROWS[i])
    begin
      axw(ROWS[i].a, ROWS[i].d);
      chk("bresp", ROWS[i].wr, r);
      axr(ROWS[i].a);
      chk("rdata", ROWS[i].rd, d);
      chk("rresp", ROWS[i].rr, r);
    end
    // full page back to back, base low byte 80, onto erased cells
    for (int i = 0; i < PAGE_BYTES; i++)
    begin
      @(posedge aclk);
      fl_req <= '{1'b1, 1'b1, 19'h00080 + 19'(i), 8'(i) ^ 8'h5a};
    end
    @(posedge aclk);
    fl_req.req <= 1'b0;
    axr(STATUS_OFS);
    chk("count", CNT_FULL, d[ST_CNT_LSB +: 8]);
    // the watchdog that bounds the pulse lives outside this block
    axw(LOWER_CTRL_OFS, 32'h50);
    axw(LOWER_CTRL_OFS, 32'h51);
    // the pulse flop follows the stored control one edge later
    @(posedge aclk);
    chk("prog on", 32'h1, arr_prog);
    axr(STATUS_OFS);
    chk("lower prog", 32'h1, d[ST_LOWER_PROG]);
    chk("upper prog", 32'h0, d[ST_UPPER_PROG]);
    fl_rd(19'h00100, 1'b1, READ_INVALID);
    // data lags the index by one cycle
    pp = 1'b0;
    pi = '0;
    repeat (16)
    begin
      @(posedge aclk);
      if (arr_prog && pp)
        chk("page byte", {1'b0, pi} ^ 8'h5a, arr_prog_data);
      pp = arr_prog;
      pi = arr_prog_idx;
    end
    axw(LOWER_CTRL_OFS, 32'h50);
    @(posedge aclk);
    chk("prog off", 32'h0, arr_prog);
    // pin dropped in mid-pulse, then a write while low is lost
    axw(LOWER_CTRL_OFS, 32'h51);
    flash_write_enable_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("pin stop", 32'h0, arr_prog);
    axw(LOWER_CTRL_OFS, 32'h40);
    axr(LOWER_CTRL_OFS);
    chk("pin ctrl", 32'h0, d);
    flash_write_enable_pin <= 1'b1;
    // verify reads the even word of the latched address, not the bus one
    axw(LOWER_CTRL_OFS, 32'h44);
    fl_acc(1'b1, 19'h00085, 8'hff);
    fl_rd(19'h00100, 1'b0, 16'h0084 ^ 16'hc3a5);
    // leave verify, then refill the page with reprogram and extra data
    axw(LOWER_CTRL_OFS, 32'h40);
    rpg = reprog(8'h05 ^ 8'h5a, fl_rdata[7:0]);
    // two passes only, so the extra pass is still allowed
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        @(posedge aclk);
        fl_req <= '{1'b1, 1'b1, 19'h00080 + 19'(i),
          p == 0 ? rpg : addprog(rpg, fl_rdata[7:0])};
      end
      @(posedge aclk);
      fl_req.req <= 1'b0;
      axr(STATUS_OFS);
      chk("refill count", CNT_FULL, d[ST_CNT_LSB +: 8]);
    end
    // erase pulse on the lower half shows on its own array line
    axw(LOWER_CTRL_OFS, 32'h62);
    @(posedge aclk);
    chk("erase on", 32'h1, arr_erase);
    axw(LOWER_CTRL_OFS, 32'h40);
    @(posedge aclk);
    chk("erase off", 32'h0, arr_erase);
    axw(LOWER_CTRL_OFS, 32'h00);
    axr(LOWER_CTRL_OFS);
    chk("swe off", 32'h0, d);
    end_sim;
  end
endmodule : fps_flash_seq_tb_top
